// ### verilog/pdc_regs.sv
// Our own choice: the APB register port.
`include "pdc_map.svh"

module pdc_regs (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire pdc_pkg::pdc_apb_req_t apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  ref_clk_pin,
  input  wire logic                  pd_in_window_pin,
  input  wire logic [2:0]            cp_auto_code,
  input  wire logic                  cal_done,
  output pdc_pkg::pdc_pll_cfg_t      pll_cfg,
  output logic                       lock_detect_on,
  output logic                       pll_locked,
  output logic                       sync_out_en,
  output logic                       cal_clk_en,
  output logic                       cal_start,
  output logic                       cal_busy,
  output logic                       ramp_en,
  output logic [31:0]                ramp_lower_limit,
  output logic                       irq
);
  import pdc_pkg::*;

  logic [31:0]    ramp_ctrl_ff;
  logic [31:0]    pll_ctrl_ff;
  logic [31:0]    dac_ctrl_ff;
  logic [31:0]    ramp_low_ff;
  logic [2:0]     irq_stat_ff;
  logic [2:0]     irq_mask_ff;
  logic [31:0]    prdata_ff;
  logic           pslverr_ff;
  logic [2:0]     ref_sync_ff;
  logic [1:0]     win_sync_ff;
  logic [2:0]     div_cnt_ff;
  logic [10:0]    lock_cnt_ff;
  logic           locked_ff;
  logic           cal_start_ff;
  pdc_cal_state_t cal_state_ff;
  pdc_cal_state_t nxt_cal_state;
  logic [7:0]     idx;
  logic           wr_acc;
  logic           setup;
  logic           ref_rise;
  logic           ref_tick;
  logic [10:0]    win_len;
  logic [2:0]     irq_set;
  logic           cal_go_wr;

  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == `PDC_IDX_STATUS) || (i == `PDC_IDX_RAMP_CTRL) || (i == `PDC_IDX_PLL_CTRL) ||
             (i == `PDC_IDX_DAC_CTRL) || (i == `PDC_IDX_RAMP_LOW) || (i == `PDC_IDX_IRQ_STAT) ||
             (i == `PDC_IDX_IRQ_MASK);
  endfunction

  // Byte address is four times the register index
  assign idx    = apb_req.paddr[9:2];
  assign setup  = apb_req.psel && !apb_req.penable;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && mapped(idx)
                  && (apb_req.paddr[11:10] == 2'b00);

  // Read data is fetched in the setup cycle, so every access ends after one access cycle
  assign pready  = apb_req.psel && apb_req.penable;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff && pready;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= !mapped(idx) || (apb_req.paddr[11:10] != 2'b00);
      prdata_ff  <= 32'h0000_0000;
      if (!apb_req.pwrite && apb_req.paddr[11:10] == 2'b00) begin
        case (idx)
          `PDC_IDX_STATUS:    prdata_ff <= {7'h00, locked_ff, 24'h00_0000};
          `PDC_IDX_RAMP_CTRL: prdata_ff <= ramp_ctrl_ff;
          `PDC_IDX_PLL_CTRL:  prdata_ff <= {8'h00, pll_ctrl_ff[23:8], 1'b0, pll_ctrl_ff[6:0]};
          `PDC_IDX_DAC_CTRL:  prdata_ff <= {5'h00, dac_ctrl_ff[26:25], cal_busy, dac_ctrl_ff[23:0]};
          `PDC_IDX_RAMP_LOW:  prdata_ff <= ramp_low_ff;
          `PDC_IDX_IRQ_STAT:  prdata_ff <= {29'h0000_0000, irq_stat_ff};
          `PDC_IDX_IRQ_MASK:  prdata_ff <= {29'h0000_0000, irq_mask_ff};
          default:            prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Codes below the supported range are kept as written; the analog side decides
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pll_ctrl_ff <= `PDC_RST_PLL_CTRL;
    end else if (wr_acc && idx == `PDC_IDX_PLL_CTRL) begin
      pll_ctrl_ff <= apb_req.pwdata;
    end
  end

  // Low bits are stored as software writes them; software owns their defaults
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dac_ctrl_ff <= `PDC_RST_DAC_CTRL;
    end else if (wr_acc && idx == `PDC_IDX_DAC_CTRL) begin
      dac_ctrl_ff <= {apb_req.pwdata[31:25], 1'b0, apb_req.pwdata[23:0]};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ramp_ctrl_ff <= 32'h0000_0000;
      ramp_low_ff  <= 32'h0000_0000;
    end else if (wr_acc) begin
      if (idx == `PDC_IDX_RAMP_CTRL) begin
        ramp_ctrl_ff <= apb_req.pwdata;
      end
      if (idx == `PDC_IDX_RAMP_LOW) begin
        ramp_low_ff <= apb_req.pwdata;
      end
    end
  end

  // PLL configuration decode
  always_comb begin
    pll_cfg.div_en     = pll_ctrl_ff[`PDC_BIT_DIV_EN];
    pll_cfg.div_sel    = pll_ctrl_ff[`PDC_BIT_DIV_EN] ? pll_ctrl_ff[21:20] : 2'b00;
    pll_cfg.doubler_on = pll_ctrl_ff[`PDC_BIT_DBL_EDGE] && pll_ctrl_ff[`PDC_BIT_DBL_EN];
    pll_cfg.fb_div     = pll_ctrl_ff[15:8];
    pll_cfg.mult       = {pll_ctrl_ff[15:8], 1'b0};
    pll_cfg.fb_div_ok  = pll_ctrl_ff[15:8] >= `PDC_FB_DIV_MIN;
    pll_cfg.cp_manual  = pll_ctrl_ff[`PDC_BIT_CP_MAN];
    pll_cfg.cp_code    = pll_ctrl_ff[`PDC_BIT_CP_MAN] ? pll_ctrl_ff[5:3] : cp_auto_code;
  end

  // Reference clock and phase window come from pins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_sync_ff <= 3'b000;
      win_sync_ff <= 2'b00;
    end else begin
      ref_sync_ff <= {ref_sync_ff[1:0], ref_clk_pin};
      win_sync_ff <= {win_sync_ff[0], pd_in_window_pin};
    end
  end

  assign ref_rise = ref_sync_ff[1] && !ref_sync_ff[2];

  // Divided reference: one tick per 1, 2, 4 or 8 reference edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= 3'b000;
    end else if (ref_rise) begin
      div_cnt_ff <= ref_tick ? 3'b000 : div_cnt_ff + 3'b001;
    end
  end

  // A count left over from a larger ratio ends at once instead of wrapping
  assign ref_tick = ref_rise && (div_cnt_ff >= ((3'b001 << pll_cfg.div_sel) - 3'b001));
  assign win_len  = `PDC_WIN_BASE << pll_ctrl_ff[1:0];
  assign lock_detect_on = pll_ctrl_ff[`PDC_BIT_LD_EN];

  // Lock needs win_len consecutive in-window divided reference ticks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt_ff <= 11'h000;
      locked_ff   <= 1'b0;
    end else if (!lock_detect_on || !win_sync_ff[1]) begin
      lock_cnt_ff <= 11'h000;
      locked_ff   <= 1'b0;
    end else if (ref_tick && !locked_ff) begin
      if (lock_cnt_ff + 11'h001 >= win_len) begin
        locked_ff <= 1'b1;
      end
      lock_cnt_ff <= lock_cnt_ff + 11'h001;
    end
  end

  assign pll_locked = locked_ff;

  // Power-downs of sync output and calibration clock
  assign sync_out_en = !dac_ctrl_ff[`PDC_BIT_SYNC_PD];
  assign cal_clk_en  = !dac_ctrl_ff[`PDC_BIT_CAL_PD] && !dac_ctrl_ff[`PDC_BIT_SYNC_PD];

  // Calibration: a start waits until its clock runs, since it cannot progress without it
  assign cal_go_wr = wr_acc && idx == `PDC_IDX_DAC_CTRL && apb_req.pwdata[`PDC_BIT_CAL_GO];

  always_comb begin
    nxt_cal_state = cal_state_ff;
    case (cal_state_ff)
      CAL_IDLE: if (cal_go_wr) nxt_cal_state = CAL_WAIT;
      CAL_WAIT: if (cal_clk_en) nxt_cal_state = CAL_RUN;
      CAL_RUN:  if (cal_done) nxt_cal_state = CAL_IDLE;
      default:  nxt_cal_state = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cal_state_ff <= CAL_IDLE;
      cal_start_ff <= 1'b0;
    end else begin
      cal_state_ff <= nxt_cal_state;
      cal_start_ff <= (cal_state_ff == CAL_WAIT) && cal_clk_en;
    end
  end

  assign cal_start = cal_start_ff;
  assign cal_busy  = cal_state_ff != CAL_IDLE;

  // Ramp lower limit only counts while the ramp is enabled
  assign ramp_en          = ramp_ctrl_ff[`PDC_BIT_RAMP_EN];
  assign ramp_lower_limit = ramp_en ? ramp_low_ff : 32'h0000_0000;

  // Sticky events; a new event wins over a write-one clear in the same cycle
  assign irq_set[`PDC_IRQ_CAL_DONE]  = (cal_state_ff == CAL_RUN) && cal_done;
  assign irq_set[`PDC_IRQ_LOCK_GAIN] = lock_detect_on && win_sync_ff[1] && ref_tick && !locked_ff
                                       && (lock_cnt_ff + 11'h001 >= win_len);
  assign irq_set[`PDC_IRQ_LOCK_LOSS] = locked_ff && (!lock_detect_on || !win_sync_ff[1]);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_ff <= 3'b000;
      irq_mask_ff <= 3'b000;
    end else begin
      if (wr_acc && idx == `PDC_IDX_IRQ_MASK) begin
        irq_mask_ff <= apb_req.pwdata[2:0];
      end
      if (wr_acc && idx == `PDC_IDX_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~apb_req.pwdata[2:0]) | irq_set;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_set;
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Checks
  logic [10:0] win_seen_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      win_seen_ff <= 11'h000;
    end else if (!lock_detect_on || !win_sync_ff[1]) begin
      win_seen_ff <= 11'h000;
    end else if (ref_tick && win_seen_ff != 11'h7ff) begin
      win_seen_ff <= win_seen_ff + 11'h001;
    end
  end

  no_bypass_div_a: assert property (@(posedge clock) disable iff (!arst_n)
    !pll_cfg.div_en |-> pll_cfg.div_sel == 2'b00) else $error("input divider not bypassed");

  doubler_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
    pll_cfg.doubler_on == (pll_ctrl_ff[16] && pll_ctrl_ff[19])) else $error("doubler gating wrong");

  fb_reset_a: assert property (@(posedge clock) $rose(arst_n) |-> pll_cfg.fb_div == 8'd25)
    else $error("feedback divider reset value wrong");

  mult_twice_a: assert property (@(posedge clock) disable iff (!arst_n)
    pll_cfg.mult == 9'(2 * pll_cfg.fb_div)) else $error("multiplication not twice N");

  cp_select_a: assert property (@(posedge clock) disable iff (!arst_n)
    pll_cfg.cp_code == (pll_ctrl_ff[6] ? pll_ctrl_ff[5:3] : cp_auto_code)) else $error("cp code wrong");

  lock_off_a: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(lock_detect_on) |=> !pll_locked) else $error("lock kept while detection off");

  lock_early_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(pll_locked) |-> win_seen_ff >= win_len) else $error("lock before window filled");

  lock_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    setup && !apb_req.pwrite && idx == `PDC_IDX_STATUS ##1 pready |-> prdata[24] == $past(pll_locked))
    else $error("lock readback wrong");

  sync_pd_a: assert property (@(posedge clock) disable iff (!arst_n)
    dac_ctrl_ff[26] |-> !sync_out_en && !cal_clk_en) else $error("sync power-down ignored");

  cal_start_a: assert property (@(posedge clock) disable iff (!arst_n)
    cal_go_wr && !cal_busy |=> cal_busy and (cal_clk_en |=> cal_start))
    else $error("cal not started");

  ramp_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
    !ramp_en |-> ramp_lower_limit == 32'h0000_0000) else $error("ramp limit leaks when disabled");

  irq_sticky_a: assert property (@(posedge clock) disable iff (!arst_n)
    |irq_set |=> |irq_stat_ff) else $error("event not captured");

  cal_clk_a: assert property (@(posedge clock) disable iff (!arst_n)
    dac_ctrl_ff[`PDC_BIT_CAL_PD] |-> !cal_clk_en) else $error("cal clock runs while powered down");

  cal_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    cal_state_ff == CAL_WAIT && !cal_clk_en |=> !cal_start) else $error("cal started without its clock");

  cp_auto_a: assert property (@(posedge clock) disable iff (!arst_n)
    !pll_cfg.cp_manual |-> pll_cfg.cp_code == cp_auto_code) else $error("automatic cp code not used");

  div_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    pll_cfg.div_en |-> pll_cfg.div_sel == pll_ctrl_ff[21:20]) else $error("input divider code lost");

  div_tick_a: assert property (@(posedge clock) disable iff (!arst_n)
    !pll_cfg.div_en && ref_rise |-> ref_tick) else $error("bypassed divider dropped an edge");

  fb_store_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_acc && idx == `PDC_IDX_PLL_CTRL |=> pll_cfg.fb_div == $past(apb_req.pwdata[15:8]))
    else $error("feedback divider not stored");

  lock_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
    !lock_detect_on |=> !pll_locked) else $error("lock reported while detection off");

  lock_drop_a: assert property (@(posedge clock) disable iff (!arst_n)
    pll_locked && !win_sync_ff[1] |=> !pll_locked) else $error("lock kept outside window");

  lock_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(pll_locked) |-> irq_stat_ff[`PDC_IRQ_LOCK_GAIN]) else $error("lock gain event missed");

  sync_on_a: assert property (@(posedge clock) disable iff (!arst_n)
    !dac_ctrl_ff[`PDC_BIT_SYNC_PD] |-> sync_out_en) else $error("sync output off while enabled");

  cal_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
    cal_start |=> !cal_start) else $error("cal start longer than one cycle");

  busy_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    cal_busy && !cal_done |=> cal_busy) else $error("cal busy dropped early");

  ramp_pass_a: assert property (@(posedge clock) disable iff (!arst_n)
    ramp_en |-> ramp_lower_limit == ramp_low_ff) else $error("ramp limit not passed through");

  irq_wins_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_acc && idx == `PDC_IDX_IRQ_STAT |=> (irq_stat_ff & $past(irq_set)) == $past(irq_set))
    else $error("event lost to clear");

  err_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    pslverr |-> prdata == 32'h0000_0000) else $error("refused read returned data");

  wr_drop_a: assert property (@(posedge clock) disable iff (!arst_n)
    apb_req.pwrite && pslverr |=> $stable(pll_ctrl_ff) && $stable(dac_ctrl_ff) && $stable(ramp_ctrl_ff))
    else $error("refused write changed a register");

  lock_cov_c: cover property (@(posedge clock) disable iff (!arst_n) $rose(pll_locked));
  cal_cov_c:  cover property (@(posedge clock) disable iff (!arst_n) cal_state_ff == CAL_RUN ##1 !cal_busy);
  irq_cov_c:  cover property (@(posedge clock) disable iff (!arst_n) $rose(irq));
  loss_cov_c: cover property (@(posedge clock) disable iff (!arst_n) irq_set[`PDC_IRQ_LOCK_LOSS]);
  err_cov_c:  cover property (@(posedge clock) disable iff (!arst_n) pslverr);
endmodule

// ### verilog/pdc_map.svh
// Operation
// - Input divider bypassed unless bit 17 set
// - Doubler runs only when bits 16, 19 set
// - Feedback divider bits 15:8, reset 25
// - Total PLL multiplication is twice N
// - Bit 6 zero: automatic charge pump current
// - Bits 5:3 hold manual charge pump code
// - Lock detection only while bit 2 set
// - Lock window 128/256/512/1024 reference cycles; code counts divided reference ticks
// - Lock reported at status bit 24
// - Bit 26 set disables sync output circuitry
// - Calibration clock runs when bits 25, 26 clear
// - Writing one to bit 24 starts calibration
// - Lower limit used only while ramp enabled
// - Lower limit holds full 32-bit value
// - Input divider codes divide by 1/2/4/8
// - Doubler enable needs clock edge bit too
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH
`define PDC_IDX_STATUS     8'h00
`define PDC_IDX_RAMP_CTRL  8'h01
`define PDC_IDX_PLL_CTRL   8'h02
`define PDC_IDX_DAC_CTRL   8'h03
`define PDC_IDX_RAMP_LOW   8'h04
`define PDC_IDX_IRQ_STAT   8'h10
`define PDC_IDX_IRQ_MASK   8'h11
`define PDC_BIT_LOCK       24
`define PDC_BIT_RAMP_EN    19
`define PDC_BIT_DBL_EN     19
`define PDC_BIT_DIV_EN     17
`define PDC_BIT_DBL_EDGE   16
`define PDC_BIT_CP_MAN     6
`define PDC_BIT_LD_EN      2
`define PDC_BIT_SYNC_PD    26
`define PDC_BIT_CAL_PD     25
`define PDC_BIT_CAL_GO     24
`define PDC_RST_PLL_CTRL   32'h0000_1900
`define PDC_RST_DAC_CTRL   32'h0000_0000
`define PDC_FB_DIV_MIN     8'h0a
`define PDC_WIN_BASE       11'h080
`define PDC_IRQ_CAL_DONE   0
`define PDC_IRQ_LOCK_GAIN  1
`define PDC_IRQ_LOCK_LOSS  2
`endif

// ### verilog/pdc_pkg.sv
package pdc_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_WAIT = 2'b01,
    CAL_RUN  = 2'b10
  } pdc_cal_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pdc_apb_req_t;

  typedef struct packed {
    logic       div_en;
    logic [1:0] div_sel;
    logic       doubler_on;
    logic [7:0] fb_div;
    logic [8:0] mult;
    logic       fb_div_ok;
    logic       cp_manual;
    logic [2:0] cp_code;
  } pdc_pll_cfg_t;
endpackage

// ### verif/test_pll_dac_cal_control_regs.sv
`include "pdc_map.svh"

module test_pll_dac_cal_control_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import pdc_pkg::*;

  logic          clock = 1'b0;
  logic          arst_n = 1'b0;
  logic          ref_clk_pin = 1'b0;
  logic          pd_in_window_pin = 1'b0;
  logic [2:0]    cp_auto_code = 3'h0;
  logic          cal_done = 1'b0;
  pdc_apb_req_t  req = '0;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  pdc_pll_cfg_t  pll_cfg;
  logic          lock_detect_on;
  logic          pll_locked;
  logic          sync_out_en;
  logic          cal_clk_en;
  logic          cal_start;
  logic          cal_busy;
  logic          ramp_en;
  logic [31:0]   ramp_lower_limit;
  logic          irq;
  int            num_errors = 0;
  int            cmp_count = 0;
  logic [31:0]   seed = 32'd49045;
  logic [31:0]   rd;
  logic          er;
  logic [31:0]   v;
  logic [31:0]   w;
  int            n;

  pdc_regs pdc_regs_i (
    .clock            (clock),
    .arst_n           (arst_n),
    .apb_req          (req),
    .pready           (pready),
    .prdata           (prdata),
    .pslverr          (pslverr),
    .ref_clk_pin      (ref_clk_pin),
    .pd_in_window_pin (pd_in_window_pin),
    .cp_auto_code     (cp_auto_code),
    .cal_done         (cal_done),
    .pll_cfg          (pll_cfg),
    .lock_detect_on   (lock_detect_on),
    .pll_locked       (pll_locked),
    .sync_out_en      (sync_out_en),
    .cal_clk_en       (cal_clk_en),
    .cal_start        (cal_start),
    .cal_busy         (cal_busy),
    .ramp_en          (ramp_en),
    .ramp_lower_limit (ramp_lower_limit),
    .irq              (irq)
  );

  always #5 clock = ~clock;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // The automatic code is drawn from bits 30:28 of the same random word
  function logic [31:0] exp_cp(input logic [31:0] cfg);
    return {28'h000_0000, cfg[6], cfg[6] ? cfg[5:3] : cfg[30:28]};
  endfunction

  // Reference pulses to lock: window length times the input division
  function int exp_pulses(input logic [31:0] cfg);
    return (int'(`PDC_WIN_BASE) << cfg[1:0]) << (cfg[17] ? cfg[21:20] : 2'b00);
  endfunction

  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task settle();
    @(negedge clock);
  endtask

  // Request held from setup until pready is sampled high; no wait count assumed
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int k;
    @(posedge clock);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= {2'b00, idx, 2'b00};
    req.pwdata <= d;
    @(posedge clock);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Reference edges kept slower than clock/4 so the synchroniser sees each one
  task ref_pulses(input int cnt);
    repeat (cnt) begin
      repeat (4) @(posedge clock);
      ref_clk_pin <= 1'b1;
      repeat (4) @(posedge clock);
      ref_clk_pin <= 1'b0;
    end
  endtask

  task lock_test(input logic [31:0] cfg);
    int ticks;
    ticks = exp_pulses(cfg);
    apb(1'b1, `PDC_IDX_PLL_CTRL, cfg);
    @(posedge clock);
    pd_in_window_pin <= 1'b1;
    ref_pulses(ticks - 2);
    settle();
    check(32'(pll_locked), 32'h0);
    ref_pulses(4);
    repeat (4) @(posedge clock);
    settle();
    check(32'(pll_locked), 32'(cfg[2]));
    apb(1'b0, `PDC_IDX_STATUS, 32'h0);
    check(rd, {7'h0, cfg[2], 24'h0});
    pd_in_window_pin <= 1'b0;
    repeat (6) @(posedge clock);
    settle();
    check(32'(pll_locked), 32'h0);
    $display("test lock cfg=%h done", cfg);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    settle();
    check(32'(pll_cfg.fb_div), 32'd25);
    check(32'(pll_cfg.mult), 32'd50);
    check({30'h0, sync_out_en, cal_clk_en}, 32'h3);
    apb(1'b0, `PDC_IDX_PLL_CTRL, 32'h0);
    check(rd, `PDC_RST_PLL_CTRL);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      if (i < 3) v[15:8] = (i == 0) ? 8'd10 : (i == 1) ? 8'd9 : 8'hff;
      cp_auto_code <= v[30:28];
      apb(1'b1, `PDC_IDX_PLL_CTRL, v);
      settle();
      check(32'(pll_cfg.div_en), 32'(v[17]));
      check(32'(pll_cfg.div_sel), v[17] ? 32'(v[21:20]) : 32'h0);
      check(32'(pll_cfg.doubler_on), 32'(v[19] & v[16]));
      check(32'(pll_cfg.fb_div), 32'(v[15:8]));
      check(32'(pll_cfg.mult), 32'(v[15:8]) * 2);
      check(32'(pll_cfg.fb_div_ok), 32'(v[15:8] >= 8'd10));
      check(32'({pll_cfg.cp_manual, pll_cfg.cp_code}), exp_cp(v));
      check(32'(lock_detect_on), 32'(v[2]));
      apb(1'b0, `PDC_IDX_PLL_CTRL, 32'h0);
      check(rd, v & 32'h00ff_ff7f);
    end
    $display("test pll fields done");
    for (int i = 0; i < 8; i++) begin
      v = rnd() & 32'h0008_0000;
      w = rnd();
      apb(1'b1, `PDC_IDX_RAMP_CTRL, v);
      apb(1'b1, `PDC_IDX_RAMP_LOW, w);
      settle();
      check(32'(ramp_en), 32'(v[19]));
      check(ramp_lower_limit, v[19] ? w : 32'h0);
      apb(1'b0, `PDC_IDX_RAMP_LOW, 32'h0);
      check(rd, w);
    end
    apb(1'b0, 8'h05, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 8'h05, 32'hffff_ffff);
    check({31'h0, er}, 32'h1);
    $display("test ramp and unmapped done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `PDC_IDX_DAC_CTRL, 32'(k) << 25);
      settle();
      check(32'(sync_out_en), 32'(k < 2));
      check(32'(cal_clk_en), 32'(k == 0));
    end
    $display("test power-down done");
    lock_test(32'h0000_1904);
    lock_test(32'h0000_1905);
    lock_test(32'h0000_1906);
    lock_test(32'h0000_1907);
    lock_test(32'h0012_1904);
    lock_test(32'h0000_1900);
    apb(1'b1, `PDC_IDX_IRQ_STAT, 32'h7);
    apb(1'b1, `PDC_IDX_IRQ_MASK, 32'h1);
    settle();
    check(32'(irq), 32'h0);
    apb(1'b1, `PDC_IDX_DAC_CTRL, 32'h0100_0000);
    n = 0;
    do begin
      settle();
      n++;
    end while (cal_start !== 1'b1 && n < 10);
    if (cal_start !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    check(32'(cal_start), 32'h1);
    check(32'(cal_busy), 32'h1);
    apb(1'b0, `PDC_IDX_DAC_CTRL, 32'h0);
    check(rd, 32'h0100_0000);
    @(posedge clock);
    cal_done <= 1'b1;
    @(posedge clock);
    cal_done <= 1'b0;
    settle();
    check(32'(cal_busy), 32'h0);
    check(32'(irq), 32'h1);
    apb(1'b1, `PDC_IDX_IRQ_MASK, 32'h0);
    settle();
    check(32'(irq), 32'h0);
    apb(1'b1, `PDC_IDX_IRQ_MASK, 32'h1);
    apb(1'b1, `PDC_IDX_IRQ_STAT, 32'h1);
    settle();
    check(32'(irq), 32'h0);
    apb(1'b0, `PDC_IDX_IRQ_STAT, 32'h0);
    check(rd & 32'h1, 32'h0);
    $display("test calibration and interrupt done");
    finish_test();
  end
endmodule
